// File: spicx_params.svh
`ifndef SPICX_PARAMS_SVH
`define SPICX_PARAMS_SVH

`define SPICX_CLK_HZ 50000000
`define SPICX_SCLK_HZ 1000000
`define SPICX_DATA_W 8
`define SPICX_NUM_SS 32
`define SPICX_IS_MASTER 1
`define SPICX_LSB_FIRST 0
`define SPICX_MIN_HALF 2
`define SPICX_HALF_DIV(clk_hz, sclk_hz) (((clk_hz) + 2 * (sclk_hz) - 1) / (2 * (sclk_hz)))

`endif

// File: spicx_pkg.sv
package spicx_pkg;

  typedef enum logic {
    SPICX_IDLE,
    SPICX_RUN
  } spicx_state_t;

  typedef struct packed {
    logic overrun;
    logic busy;
  } spicx_status_t;

endpackage

// File: spicx_shift_if.sv
interface spicx_shift_if #(
  parameter int W = 8
);
  logic         load;
  logic [W-1:0] load_word;
  logic         shift;
  logic         sample;
  logic         in_bit;
  logic         out_bit;
  logic [W-1:0] word;

  modport core (
    output load,
    output load_word,
    output shift,
    output sample,
    output in_bit,
    input  out_bit,
    input  word
  );

  modport shifter (
    input  load,
    input  load_word,
    input  shift,
    input  sample,
    input  in_bit,
    output out_bit,
    output word
  );
endinterface

// File: spicx_shifter.sv
module spicx_shifter #(
  parameter int W         = 8,
  parameter bit LSB_FIRST = 1'b0
) (
  // Clock and reset
  input wire logic      clk,
  input wire logic      reset,
  // Shift control and data
  spicx_shift_if.shifter port
);
  logic [W-1:0] tx_sh;
  logic [W-1:0] rx_sh;

  wire [W-1:0] next_tx = LSB_FIRST ? {1'b0, tx_sh[W-1:1]} : {tx_sh[W-2:0], 1'b0};
  wire [W-1:0] next_rx = LSB_FIRST ? {port.in_bit, rx_sh[W-1:1]} : {rx_sh[W-2:0], port.in_bit};

  assign port.out_bit = LSB_FIRST ? tx_sh[0] : tx_sh[W-1];
  assign port.word    = rx_sh;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_sh <= '0;
    end else if (port.load) begin
      tx_sh <= port.load_word;
    end else if (port.shift) begin
      tx_sh <= next_tx;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_sh <= '0;
    end else if (port.sample) begin
      rx_sh <= next_rx;
    end
  end
endmodule

// File: spicx_core.sv
`include "spicx_params.svh"

module spicx_core #(
  parameter int DATA_W    = `SPICX_DATA_W,
  parameter int NUM_SS    = `SPICX_NUM_SS,
  parameter bit IS_MASTER = `SPICX_IS_MASTER,
  parameter bit LSB_FIRST = `SPICX_LSB_FIRST,
  parameter int CLK_HZ    = `SPICX_CLK_HZ,
  parameter int SCLK_HZ   = `SPICX_SCLK_HZ
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // Transmit holding word, flow controlled
  input  wire logic                 tx_valid,
  input  wire logic [DATA_W-1:0]    tx_data,
  output logic                      tx_ready,
  // Receive holding word, overwritten if unread and flagged as overrun
  output logic                      rx_valid,
  output logic [DATA_W-1:0]         rx_data,
  input  wire logic                 rx_ready,
  // Control, select mask and status
  input  wire logic [NUM_SS-1:0]    ss_mask,
  input  wire logic                 irq_tx_en,
  input  wire logic                 irq_rx_en,
  input  wire logic                 overrun_clr,
  output spicx_pkg::spicx_status_t  status,
  output logic                      irq,
  // Serial pins
  output logic                      sclk_out,
  input  wire logic                 sclk_in,
  output logic                      mosi_out,
  input  wire logic                 mosi_in,
  output logic                      miso_out,
  input  wire logic                 miso_in,
  output logic [NUM_SS-1:0]         ss_n_out,
  input  wire logic                 ss_n_in
);
  import spicx_pkg::*;

  localparam int HALF_CALC = `SPICX_HALF_DIV(CLK_HZ, SCLK_HZ);
  // Two cycles at least, so mosi settles from its register before the first rising edge.
  localparam int HALF_DIV  = (HALF_CALC < `SPICX_MIN_HALF) ? `SPICX_MIN_HALF : HALF_CALC;
  localparam int DW        = $clog2(HALF_DIV + 1);
  localparam int HW        = $clog2(2 * DATA_W) + 1;

  spicx_state_t      state;
  spicx_state_t      next_state;
  logic [DW-1:0]     div_cnt;
  logic [HW-1:0]     half_cnt;
  logic [DATA_W-1:0] tx_hold;
  logic              sclk_prev;
  logic              done_d;

  spicx_shift_if #(.W(DATA_W)) sh ();

  spicx_shifter #(
    .W         (DATA_W),
    .LSB_FIRST (LSB_FIRST)
  ) u_shifter (
    .clk   (clk),
    .reset (reset),
    .port  (sh)
  );

  wire running  = IS_MASTER && (state == SPICX_RUN);
  wire tick     = running && (div_cnt == DW'(HALF_DIV - 1));
  wire rise_m   = tick && !half_cnt[0];
  wire fall_m   = tick && half_cnt[0];
  wire last_m   = fall_m && (half_cnt == HW'(2 * DATA_W - 1));
  wire sel_s    = !IS_MASTER && !ss_n_in;
  wire rise_s   = sel_s && sclk_in && !sclk_prev;
  wire fall_s   = sel_s && !sclk_in && sclk_prev;
  wire last_s   = rise_s && (half_cnt == HW'(DATA_W - 1));
  wire busy_now = IS_MASTER ? running : sel_s;
  wire start    = !busy_now && !tx_ready;
  wire done     = IS_MASTER ? last_m : last_s;
  wire tx_take  = tx_valid && tx_ready;
  wire rx_lost  = done_d && rx_valid && !rx_ready;

  wire [DW-1:0] next_div  = tick ? '0 : div_cnt + DW'(1);
  wire [HW-1:0] next_half = (last_m || last_s) ? '0 : half_cnt + HW'(1);
  wire          hop       = tick || rise_s;

  assign sh.load      = start;
  assign sh.load_word = tx_hold;
  assign sh.sample    = rise_m || rise_s;
  assign sh.shift     = (fall_m && !last_m) || fall_s;
  assign sh.in_bit    = IS_MASTER ? miso_in : mosi_in;

  always_comb begin
    next_state = state;
    unique case (state)
      SPICX_IDLE: if (IS_MASTER && start) begin
        next_state = SPICX_RUN;
      end
      SPICX_RUN: if (last_m) begin
        next_state = SPICX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= SPICX_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= running ? next_div : '0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      half_cnt <= '0;
    end else if (!busy_now) begin
      half_cnt <= '0;
    end else if (hop) begin
      half_cnt <= next_half;
    end
  end

  // Transmit holding word: accepted while ready, then moved to the shifter when idle.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_ready <= 1'b1;
      tx_hold  <= '0;
    end else if (start) begin
      tx_ready <= 1'b1;
    end else if (tx_take) begin
      tx_ready <= 1'b0;
      tx_hold  <= tx_data;
    end
  end

  // In a slave build the last sample lands in the shifter on the done cycle, so capture one cycle later.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_d <= 1'b0;
    end else begin
      done_d <= done;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_valid <= 1'b0;
      rx_data  <= '0;
    end else if (done_d) begin
      rx_valid <= 1'b1;
      rx_data  <= sh.word;
    end else if (rx_ready) begin
      rx_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status <= '0;
    end else begin
      status.busy    <= busy_now;
      status.overrun <= rx_lost || (status.overrun && !overrun_clr);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= (irq_rx_en && rx_valid) || (irq_tx_en && tx_ready);
    end
  end

  // Serial pins, all from registers.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_out  <= 1'b0;
      sclk_prev <= 1'b0;
      mosi_out  <= 1'b0;
      miso_out  <= 1'b0;
      ss_n_out  <= '1;
    end else begin
      sclk_prev <= sclk_in;
      sclk_out  <= running && (rise_m || (sclk_out && !fall_m));
      mosi_out  <= IS_MASTER && sh.out_bit;
      miso_out  <= !IS_MASTER && sh.out_bit;
      ss_n_out  <= running ? ~ss_mask : '1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  tx_accept_a: assert property (tx_take |=> !tx_ready && tx_hold == $past(tx_data))
    else $error("Transmit word not held after accept.");
  tx_move_a: assert property (!tx_ready && !busy_now |=> tx_ready)
    else $error("Holding word not moved while idle.");
  rx_capture_a: assert property (done |-> ##2 rx_valid)
    else $error("Finished transfer did not reach the receive word.");
  irq_raise_a: assert property (irq_rx_en && rx_valid |=> irq)
    else $error("Interrupt not raised on received word.");
  ss_select_a: assert property (running |=> ss_n_out == ~$past(ss_mask))
    else $error("Select lines do not follow the mask.");
  ss_idle_a: assert property (!IS_MASTER || !$past(running) |-> ss_n_out == '1)
    else $error("Select asserted outside a transfer.");
  sclk_rate_a: assert property (running && $changed(sclk_out) && $past(running)
                                |-> $past(div_cnt) == DW'(HALF_DIV - 1))
    else $error("Sclk edge off the divider boundary.");
  mosi_path_a: assert property (IS_MASTER |=> mosi_out == $past(sh.out_bit))
    else $error("Mosi does not follow the shifter.");
  miso_path_a: assert property (sel_s |=> miso_out == $past(sh.out_bit))
    else $error("Miso does not follow the shifter when selected.");
  master_len_a: assert property (start && IS_MASTER |-> ##HALF_DIV !sclk_out ##1 sclk_out)
    else $error("First sclk rise late or early.");

  xfer_done_c: cover property (done ##2 rx_valid);
  double_buf_c: cover property (busy_now && tx_take);
  overrun_c: cover property (rx_lost);
endmodule

// File: spicx_slave_model.sv
module spicx_slave_model (
  // Serial pins
  input  wire logic       sclk,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  // Reply word and word seen on mosi
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic [7:0]      got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;
  logic       last;
  initial begin
    sh = 8'h00;
    got = 8'h00;
    last = 1'b0;
  end
  always @(negedge ss_n) sh = reply;
  always @(posedge sclk) if (!ss_n) got = {got[6:0], mosi};
  always @(negedge sclk) if (!ss_n) sh = {sh[6:0], 1'b0};
  always @(sh or ss_n) if (!ss_n) last = sh[7];
  // A floating line is shown as the inverse of the last bit, so a stale sample is caught.
  assign miso = ss_n ? ~last : sh[7];
endmodule

// File: test_spi_core_transmit_path.sv
module test_spi_core_transmit_path;
  timeunit 1ns;
  timeprecision 1ns;
  import spicx_pkg::*;
  logic          clk, reset, tx_valid, tx_ready, rx_valid, rx_ready, irq, sclk_q;
  logic          irq_tx_en, irq_rx_en, overrun_clr, sclk_out, mosi_out, miso_out, miso_in;
  logic [7:0]    tx_data, rx_data, reply, got, gap, cyc, mark;
  logic [31:0]   ss_mask, ss_n_out, last_ss;
  spicx_status_t status;
  int            miscompares, cmp_count, frames;
  logic [7:0]    got_q[$];
  logic          sclk_in, mosi_in, ss_n_in, miso_out_s, rx_valid_s;
  logic [7:0]    rx_data_s, miso_word;

  spicx_core #(.SCLK_HZ(12500000)) dut_u (
    .clk(clk), .reset(reset), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .ss_mask(ss_mask),
    .irq_tx_en(irq_tx_en), .irq_rx_en(irq_rx_en), .overrun_clr(overrun_clr), .status(status),
    .irq(irq), .sclk_out(sclk_out), .sclk_in(1'b0), .mosi_out(mosi_out), .mosi_in(1'b0),
    .miso_out(miso_out), .miso_in(miso_in), .ss_n_out(ss_n_out), .ss_n_in(1'b1));

  spicx_slave_model slave_u (
    .sclk(sclk_out), .ss_n(ss_n_out[5]), .mosi(mosi_out), .reply(reply), .miso(miso_in), .got(got));

  // A second core built as a slave; the bench plays the remote master on its pins.
  spicx_core #(.IS_MASTER(1'b0), .SCLK_HZ(12500000)) dut_slave_u (
    .clk(clk), .reset(reset), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(),
    .rx_valid(rx_valid_s), .rx_data(rx_data_s), .rx_ready(rx_ready), .ss_mask(ss_mask),
    .irq_tx_en(irq_tx_en), .irq_rx_en(irq_rx_en), .overrun_clr(overrun_clr), .status(),
    .irq(), .sclk_out(), .sclk_in(sclk_in), .mosi_out(), .mosi_in(mosi_in),
    .miso_out(miso_out_s), .miso_in(1'b0), .ss_n_out(), .ss_n_in(ss_n_in));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Track the select pattern and the clock count between serial clock rises.
  always @(posedge clk) begin
    sclk_q <= sclk_out;
    cyc <= cyc + 8'h01;
    if (ss_n_out !== 32'hFFFFFFFF) last_ss <= ss_n_out;
    if (sclk_out && !sclk_q) begin
      gap <= cyc - mark;
      mark <= cyc;
    end
  end

  always @(posedge ss_n_out[5]) if (!reset) begin
    got_q.push_back(got);
    frames++;
  end

  task chk(input string name, input logic [31:0] exp, input logic [31:0] act);
    cmp_count++;
    if (act !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, act);
    end
  endtask

  task send(input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    #2 tx_valid = 1'b1;
    tx_data = d;
    @(posedge clk);
    while (tx_ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (tx_ready !== 1'b1) chk("tx_ready", 32'h1, tx_ready);
    #2 tx_valid = 1'b0;
  endtask

  task wait_frames(input int want);
    int k;
    k = 0;
    while (frames < want && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (frames < want) chk("frames", want, frames);
    repeat (4) @(posedge clk);
    #2;
  endtask

  // Mode 0 frame into the slave build, MSB first; each sclk level stands for two clocks.
  task slave_xfer(input logic [7:0] d);
    int i;
    i = 0;
    @(posedge clk);
    #2 ss_n_in = 1'b0;
    for (i = 0; i < 8; i++) begin
      mosi_in = d[7 - i];
      repeat (2) @(posedge clk);
      #2 miso_word = {miso_word[6:0], miso_out_s};
      sclk_in = 1'b1;
      repeat (2) @(posedge clk);
      #2 sclk_in = 1'b0;
    end
    repeat (4) @(posedge clk);
    #2 ss_n_in = 1'b1;
  endtask

  task results;
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    results;
  end

  initial begin
    reset = 1'b1;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    rx_ready = 1'b0;
    ss_mask = 32'h00000020;
    irq_tx_en = 1'b1;
    irq_rx_en = 1'b0;
    overrun_clr = 1'b0;
    reply = 8'hC3;
    frames = 0;
    cyc = 8'h00;
    mark = 8'h00;
    sclk_q = 1'b0;
    last_ss = 32'hFFFFFFFF;
    sclk_in = 1'b0;
    mosi_in = 1'b0;
    ss_n_in = 1'b1;
    miso_word = 8'h00;
    repeat (8) @(posedge clk);
    chk("ss_n_out", 32'hFFFFFFFF, ss_n_out);
    chk("tx_ready", 32'h1, tx_ready);
    #2 reset = 1'b0;
    repeat (2) @(posedge clk);
    #2 chk("irq", 32'h1, irq);
    // One word to one slave, reply returned on the data-in pin.
    send(8'hA5);
    wait_frames(1);
    chk("rx_data", 32'hC3, rx_data);
    chk("mosi word", 32'hA5, got_q.pop_front());
    chk("select", 32'hFFFFFFDF, last_ss);
    chk("sclk gap", 32'h4, gap);
    // Second word is written while the first one is still shifting, and nobody reads.
    ss_mask = 32'h80000021;
    reply = 8'h5A;
    send(8'h3C);
    send(8'h81);
    repeat (2) @(posedge clk);
    #2 chk("busy", 32'h1, status.busy);
    wait_frames(3);
    chk("mosi word", 32'h3C, got_q.pop_front());
    chk("mosi word", 32'h81, got_q.pop_front());
    chk("select", 32'h7FFFFFDE, last_ss);
    chk("overrun", 32'h1, status.overrun);
    chk("rx_data", 32'h5A, rx_data);
    irq_tx_en = 1'b0;
    irq_rx_en = 1'b1;
    repeat (2) @(posedge clk);
    #2 chk("irq", 32'h1, irq);
    rx_ready = 1'b1;
    overrun_clr = 1'b1;
    @(posedge clk);
    #2 rx_ready = 1'b0;
    overrun_clr = 1'b0;
    repeat (2) @(posedge clk);
    #2 chk("overrun", 32'h0, status.overrun);
    chk("rx_valid", 32'h0, rx_valid);
    chk("irq", 32'h0, irq);
    chk("ss_n_out", 32'hFFFFFFFF, ss_n_out);
    chk("tx_ready", 32'h1, tx_ready);
    chk("miso_out", 32'h0, miso_out);
    // The slave build took every word as well, so its last one goes out on miso.
    slave_xfer(8'h96);
    chk("slave rx_data", 32'h96, rx_data_s);
    chk("slave rx_valid", 32'h1, rx_valid_s);
    chk("miso word", 32'h81, miso_word);
    results;
  end
endmodule
